/* inc/converter_config_map.svh */
// Offsets, field positions, reset values and timing constants of the converter configuration bank
`ifndef CONVERTER_CONFIG_MAP_SVH
`define CONVERTER_CONFIG_MAP_SVH

`define REG_WRITE_LOCK 8'h10
`define REG_MAX_DUTY 8'hbf
`define REG_BOOT_REFRESH 8'hec
`define REG_THRESHOLDS 8'hed

`define RST_WRITE_LOCK 8'h00
`define RST_MAX_DUTY 8'h00
`define RST_BOOT_REFRESH 8'h00
`define RST_THRESHOLDS 8'h00

`define MASK_WRITE_LOCK 8'h80
`define MASK_MAX_DUTY 8'h07
`define MASK_BOOT_REFRESH 8'h5f
`define MASK_THRESHOLDS 8'h3f

`define LOCK_BIT 7
`define BR_WIDTH_BIT 3
`define BR_COUNT_BIT 4
`define BR_BLANK_BIT 6

`define CLK_FREQ_KHZ 25000
`define TICK_US 1
`define TICK_CYCLES (`CLK_FREQ_KHZ * `TICK_US / 1000)

`define BR_INT0_US 11'd500
`define BR_INT1_US 11'd100
`define BR_INT2_US 11'd200
`define BR_INT3_US 11'd300
`define BR_INT4_US 11'd750
`define BR_INT5_US 11'd1000
`define BR_INT6_US 11'd1500
`define BR_INT7_US 11'd2000

`define BR_INIT_HI 5'd16
`define BR_EVENT_HI 5'd8
`define BR_EVENT_LO 5'd4
`define BR_INIT_LO_DEFAULT 8

`define BR_DIV_NARROW 4'd12
`define BR_DIV_WIDE 4'd6

`define BLANK_SHORT_US 1500
`define BLANK_LONG_US 10000

`define DUTY_0 10'd917
`define DUTY_1 10'd958
`define DUTY_2 10'd875
`define DUTY_3 10'd833
`define DUTY_4 10'd792
`define DUTY_5 10'd750

`define CC_LOOP_BASE_MV 12'd2400
`define AVG_LIMIT_BASE_MV 12'd2700
`define THR_STEP_MV 12'd100

`define DEV_ADDR_DEFAULT 7'h40

`endif

/* inc/converter_config_pkg.sv */
// Types shared by the converter configuration bank
package converter_config_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CMD_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8,
    ST_WAIT = 4'h9
  } link_state_t;
endpackage : converter_config_pkg

/* verilog/boot_refresh_timer.sv */
// Boot refresh burst sequencer: spaces a counted burst of refresh requests
`timescale 1ns/1ps
`include "converter_config_map.svh"
module boot_refresh_timer #(
  parameter int INIT_COUNT_LO = `BR_INIT_LO_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tick_us,
  input wire logic [2:0] i_interval_code,
  input wire logic i_count_sel,
  input wire logic i_start_initial,
  input wire logic i_start_event,
  output logic o_refresh_pulse,
  output logic o_busy
);
  logic [10:0] us_count;
  logic [4:0] remaining;

  function automatic logic [10:0] interval_us(input logic [2:0] code);
    case (code)
      3'h0: interval_us = `BR_INT0_US;
      3'h1: interval_us = `BR_INT1_US;
      3'h2: interval_us = `BR_INT2_US;
      3'h3: interval_us = `BR_INT3_US;
      3'h4: interval_us = `BR_INT4_US;
      3'h5: interval_us = `BR_INT5_US;
      3'h6: interval_us = `BR_INT6_US;
      default: interval_us = `BR_INT7_US;
    endcase
  endfunction : interval_us

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      us_count <= 11'h000;
      remaining <= 5'h00;
      o_refresh_pulse <= 1'b0;
    end else begin
      o_refresh_pulse <= 1'b0;
      if (i_start_initial) begin
        remaining <= i_count_sel ? `BR_INIT_HI : INIT_COUNT_LO[4:0];
        us_count <= 11'h000;
      end else if (i_start_event) begin
        remaining <= i_count_sel ? `BR_EVENT_HI : `BR_EVENT_LO;
        us_count <= 11'h000;
      end else if (i_tick_us && remaining != 5'h00) begin
        // Interval code is read live, so a rewrite retimes the burst in flight
        if (us_count >= interval_us(i_interval_code) - 11'd1) begin
          us_count <= 11'h000;
          remaining <= remaining - 5'd1;
          o_refresh_pulse <= 1'b1;
        end else begin
          us_count <= us_count + 11'd1;
        end
      end
    end
  end

  assign o_busy = (remaining != 5'h00);
endmodule : boot_refresh_timer

/* verilog/converter_config_regs.sv */
// Converter configuration registers behind a byte-wide PMBus slave
`timescale 1ns/1ps
`include "converter_config_map.svh"
module converter_config_regs #(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
  parameter int BLANK_SHORT_US = `BLANK_SHORT_US,
  parameter int BLANK_LONG_US = `BLANK_LONG_US,
  parameter int INIT_COUNT_LO = `BR_INIT_LO_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic i_boost_mode,
  input wire logic i_phase_added,
  input wire logic i_start_initial,
  input wire logic i_start_event,
  output logic [9:0] o_hs_duty_limit,
  output logic [9:0] o_ls_duty_limit,
  output logic [9:0] o_flyback_duty_limit,
  output logic o_refresh_pulse,
  output logic o_refresh_busy,
  output logic [3:0] o_refresh_width_div,
  output logic o_phase_drop_allowed,
  output logic [11:0] o_constant_current_loop_mv,
  output logic [11:0] o_average_current_limit_mv,
  output logic o_write_locked
);
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  converter_config_pkg::link_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic is_read;
  logic [7:0] cmd;
  logic [7:0] tx_byte;
  logic wr_strobe;
  logic [7:0] wr_data;
  logic [7:0] write_lock_control;
  logic [7:0] max_duty_setting;
  logic [7:0] boot_refresh_control;
  logic [7:0] current_loop_thresholds;
  logic [4:0] tick_div;
  logic tick_us;
  logic [13:0] blank_count;
  logic [9:0] duty;
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    case (addr)
      `REG_WRITE_LOCK: read_reg = write_lock_control & `MASK_WRITE_LOCK;
      `REG_MAX_DUTY: read_reg = max_duty_setting & `MASK_MAX_DUTY;
      `REG_BOOT_REFRESH: read_reg = boot_refresh_control & `MASK_BOOT_REFRESH;
      `REG_THRESHOLDS: read_reg = current_loop_thresholds & `MASK_THRESHOLDS;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg
  function automatic logic [11:0] threshold_mv(input logic [11:0] base, input logic [2:0] code);
    threshold_mv = base - `THR_STEP_MV * {9'h000, code};
  endfunction : threshold_mv
  // Pins: three stages, a level counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], i_scl};
      sda_sync <= {sda_sync[1:0], i_sda};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
    end
  end
  assign scl_rise = (scl_sync[1] == scl_sync[2]) && scl_sync[2] && !scl_f;
  assign scl_fall = (scl_sync[1] == scl_sync[2]) && !scl_sync[2] && scl_f;
  assign start_cond = scl_f && (sda_sync[1] == sda_sync[2]) && !sda_sync[2] && sda_f;
  assign stop_cond = scl_f && (sda_sync[1] == sda_sync[2]) && sda_sync[2] && !sda_f;
  // Byte-level link state machine: write byte and read byte with repeated start
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state <= converter_config_pkg::ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      is_read <= 1'b0;
      cmd <= 8'h00;
      tx_byte <= 8'h00;
      o_sda_oe_n <= 1'b1;
      wr_strobe <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (start_cond) begin
        state <= converter_config_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        o_sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state <= converter_config_pkg::ST_IDLE;
        o_sda_oe_n <= 1'b1;
      end else begin
        case (state)
          converter_config_pkg::ST_ADDR,
          converter_config_pkg::ST_CMD,
          converter_config_pkg::ST_WDATA: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall && bit_cnt == 4'd8) begin
              bit_cnt <= 4'h0;
              if (state == converter_config_pkg::ST_ADDR) begin
                if (shift[7:1] == DEV_ADDR) begin
                  is_read <= shift[0];
                  o_sda_oe_n <= 1'b0;
                  state <= converter_config_pkg::ST_ADDR_ACK;
                end else begin
                  state <= converter_config_pkg::ST_WAIT;
                end
              end else if (state == converter_config_pkg::ST_CMD) begin
                cmd <= shift;
                o_sda_oe_n <= 1'b0;
                state <= converter_config_pkg::ST_CMD_ACK;
              end else begin
                wr_data <= shift;
                wr_strobe <= 1'b1;
                o_sda_oe_n <= 1'b0;
                state <= converter_config_pkg::ST_WDATA_ACK;
              end
            end
          end
          converter_config_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (is_read) begin
                tx_byte <= read_reg(cmd);
                o_sda_oe_n <= read_reg(cmd) >> 7 != 8'h00;
                state <= converter_config_pkg::ST_RDATA;
              end else begin
                o_sda_oe_n <= 1'b1;
                state <= converter_config_pkg::ST_CMD;
              end
            end
          end
          converter_config_pkg::ST_CMD_ACK,
          converter_config_pkg::ST_WDATA_ACK: begin
            // Every byte after the command is data; extra bytes hit the same register
            if (scl_fall) begin
              o_sda_oe_n <= 1'b1;
              state <= converter_config_pkg::ST_WDATA;
            end
          end
          converter_config_pkg::ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'd8) begin
                bit_cnt <= 4'h0;
                o_sda_oe_n <= 1'b1;
                state <= converter_config_pkg::ST_RDATA_ACK;
              end else begin
                tx_byte <= {tx_byte[6:0], 1'b0};
                o_sda_oe_n <= tx_byte[6];
              end
            end
          end
          converter_config_pkg::ST_RDATA_ACK: begin
            if (scl_rise) begin
              is_read <= !sda_f;
            end else if (scl_fall) begin
              if (is_read) begin
                tx_byte <= read_reg(cmd);
                o_sda_oe_n <= read_reg(cmd) >> 7 != 8'h00;
                state <= converter_config_pkg::ST_RDATA;
              end else begin
                state <= converter_config_pkg::ST_WAIT;
              end
            end
          end
          converter_config_pkg::ST_IDLE,
          converter_config_pkg::ST_WAIT: begin
            o_sda_oe_n <= 1'b1;
          end
          default: begin
            state <= converter_config_pkg::ST_IDLE;
            o_sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end
  assign o_sda = 1'b0;
  // Register file; the lock register always accepts so a locked part can be unlocked
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      write_lock_control <= `RST_WRITE_LOCK;
      max_duty_setting <= `RST_MAX_DUTY;
      boot_refresh_control <= `RST_BOOT_REFRESH;
      current_loop_thresholds <= `RST_THRESHOLDS;
    end else if (wr_strobe) begin
      if (cmd == `REG_WRITE_LOCK) begin
        write_lock_control <= wr_data & `MASK_WRITE_LOCK;
      end else if (!write_lock_control[`LOCK_BIT]) begin
        case (cmd)
          `REG_MAX_DUTY: max_duty_setting <= wr_data & `MASK_MAX_DUTY;
          `REG_BOOT_REFRESH: boot_refresh_control <= wr_data & `MASK_BOOT_REFRESH;
          `REG_THRESHOLDS: current_loop_thresholds <= wr_data & `MASK_THRESHOLDS;
          default: begin
          end
        endcase
      end
    end
  end
  // One microsecond enable for the slow timers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tick_div <= 5'h00;
      tick_us <= 1'b0;
    end else if (tick_div == 5'(`TICK_CYCLES - 1)) begin
      tick_div <= 5'h00;
      tick_us <= 1'b1;
    end else begin
      tick_div <= tick_div + 5'd1;
      tick_us <= 1'b0;
    end
  end
  // Phase drop blanking; a new phase add restarts the window
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      blank_count <= 14'h0000;
    end else if (i_phase_added) begin
      blank_count <= boot_refresh_control[`BR_BLANK_BIT] ? 14'(BLANK_LONG_US) :
                     14'(BLANK_SHORT_US);
    end else if (tick_us && blank_count != 14'h0000) begin
      blank_count <= blank_count - 14'd1;
    end
  end
  // Unassigned duty codes fall back to the tightest limit rather than the loosest
  always_comb begin
    case (max_duty_setting[2:0])
      3'h0: duty = `DUTY_0;
      3'h1: duty = `DUTY_1;
      3'h2: duty = `DUTY_2;
      3'h3: duty = `DUTY_3;
      3'h4: duty = `DUTY_4;
      3'h5: duty = `DUTY_5;
      default: duty = `DUTY_5;
    endcase
  end
  // Decoded settings, registered so the analog side sees clean levels
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_hs_duty_limit <= `DUTY_0;
      o_ls_duty_limit <= `DUTY_0;
      o_flyback_duty_limit <= `DUTY_0;
      o_refresh_width_div <= `BR_DIV_NARROW;
      o_phase_drop_allowed <= 1'b1;
      o_constant_current_loop_mv <= `CC_LOOP_BASE_MV;
      o_average_current_limit_mv <= `AVG_LIMIT_BASE_MV;
      o_write_locked <= 1'b0;
    end else begin
      // The switch that is not the main switch is left unlimited (1000 per mille)
      o_hs_duty_limit <= i_boost_mode ? 10'd1000 : duty;
      o_ls_duty_limit <= i_boost_mode ? duty : 10'd1000;
      o_flyback_duty_limit <= duty;
      o_refresh_width_div <= boot_refresh_control[`BR_WIDTH_BIT] ? `BR_DIV_WIDE :
                             `BR_DIV_NARROW;
      o_phase_drop_allowed <= (blank_count == 14'h0000) && !i_phase_added;
      o_constant_current_loop_mv <= threshold_mv(`CC_LOOP_BASE_MV,
                                                 current_loop_thresholds[2:0]);
      o_average_current_limit_mv <= threshold_mv(`AVG_LIMIT_BASE_MV,
                                                 current_loop_thresholds[5:3]);
      o_write_locked <= write_lock_control[`LOCK_BIT];
    end
  end
  boot_refresh_timer #(
    .INIT_COUNT_LO(INIT_COUNT_LO)
  ) u_refresh (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick_us(tick_us),
    .i_interval_code(boot_refresh_control[2:0]),
    .i_count_sel(boot_refresh_control[`BR_COUNT_BIT]),
    .i_start_initial(i_start_initial),
    .i_start_event(i_start_event),
    .o_refresh_pulse(o_refresh_pulse),
    .o_busy(o_refresh_busy)
  );
endmodule : converter_config_regs

/* bench/pmbus_host_model.sv */
// PMBus host model driving the bus clock and data lines
`timescale 1ns/1ps
module pmbus_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask : w
  // Data moves only while the clock is low, clear of both clock edges
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    w(6);
    o_scl = 1'b1;
    w(6);
    r = i_sda;
    o_scl = 1'b0;
    w(4);
  endtask : bit_io
  task automatic start();
    o_sda = 1'b1;
    w(4);
    o_scl = 1'b1;
    w(6);
    o_sda = 1'b0;
    w(6);
    o_scl = 1'b0;
    w(4);
  endtask : start
  task automatic stop();
    o_sda = 1'b0;
    w(6);
    o_scl = 1'b1;
    w(6);
    o_sda = 1'b1;
    w(6);
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send
  task automatic recv(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask : recv
endmodule : pmbus_host_model

/* bench/converter_config_regs_chk.sv */
// Port assertions for the converter configuration bank
`timescale 1ns/1ps
module converter_config_regs_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_boost_mode,
  input wire logic i_phase_added,
  input wire logic i_start_initial,
  input wire logic i_start_event,
  input wire logic o_sda_oe_n,
  input wire logic [9:0] o_hs_duty_limit,
  input wire logic [9:0] o_ls_duty_limit,
  input wire logic [9:0] o_flyback_duty_limit,
  input wire logic o_refresh_pulse,
  input wire logic o_refresh_busy,
  input wire logic [3:0] o_refresh_width_div,
  input wire logic o_phase_drop_allowed,
  input wire logic [11:0] o_constant_current_loop_mv,
  input wire logic [11:0] o_average_current_limit_mv,
  input wire logic o_write_locked
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  AST_MAIN_BOOST: assert property (
    i_boost_mode [*3] |-> o_hs_duty_limit == 10'h3e8 && o_ls_duty_limit == o_flyback_duty_limit
  ) else $error("boost limits wrong");
  AST_MAIN_BUCK: assert property (
    !i_boost_mode [*3] |-> o_ls_duty_limit == 10'h3e8 && o_hs_duty_limit == o_flyback_duty_limit
  ) else $error("buck limits wrong");
  AST_DUTY_SET: assert property (
    o_flyback_duty_limit inside {10'h395, 10'h3be, 10'h36b, 10'h341, 10'h318, 10'h2ee}
  ) else $error("duty value outside table");
  AST_WIDTH_DIV: assert property (
    o_refresh_width_div inside {4'hc, 4'h6}
  ) else $error("width divider wrong");
  AST_CONSTANT_CURRENT_LOOP_STEP: assert property (
    o_constant_current_loop_mv >= 12'h6a4 && o_constant_current_loop_mv <= 12'h960 &&
    o_constant_current_loop_mv % 12'h064 == 12'h000
  ) else $error("current loop threshold off grid");
  AST_AVERAGE_CURRENT_LIMIT_STEP: assert property (
    o_average_current_limit_mv >= 12'h7d0 && o_average_current_limit_mv <= 12'ha8c &&
    o_average_current_limit_mv % 12'h064 == 12'h000
  ) else $error("average limit threshold off grid");
  AST_BLANK_START: assert property (
    i_phase_added |=> !o_phase_drop_allowed
  ) else $error("blanking did not start");
  AST_BLANK_HOLD: assert property (
    $fell(o_phase_drop_allowed) |-> !o_phase_drop_allowed [*8]
  ) else $error("blanking too short");
  AST_PULSE_SINGLE: assert property (
    o_refresh_pulse |=> !o_refresh_pulse
  ) else $error("refresh pulses too close");
  AST_FIRST_WAIT: assert property (
    $rose(o_refresh_busy) |-> !o_refresh_pulse [*8]
  ) else $error("first refresh pulse too early");
  AST_BUSY_CAUSE: assert property (
    $rose(o_refresh_busy) |-> $past(i_start_initial) || $past(i_start_event)
  ) else $error("burst began without a start");
  // Lock may only move on a byte the device acknowledged
  AST_LOCK_BY_BUS: assert property (
    $changed(o_write_locked) |-> !$past(o_sda_oe_n) || !$past(o_sda_oe_n, 2)
  ) else $error("lock changed without a bus write");
  cover property (o_refresh_pulse);
  cover property ($rose(o_write_locked));
  cover property ($fell(o_phase_drop_allowed));
  cover property (i_boost_mode [*3]);
endmodule : converter_config_regs_chk

/* bench/converter_config_regs_test.sv */
// Self-checking bench for the converter configuration bank
`timescale 1ns/1ps
`include "converter_config_map.svh"
module converter_config_regs_test;
  localparam int BS = 12;
  localparam int BL = 40;
  localparam logic [9:0] DUTY [8] = '{10'h395, 10'h3be, 10'h36b, 10'h341,
    10'h318, 10'h2ee, 10'h2ee, 10'h2ee};
  localparam logic [7:0] REGS [4] = '{`REG_WRITE_LOCK, `REG_MAX_DUTY,
    `REG_BOOT_REFRESH, `REG_THRESHOLDS};
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_boost_mode = 1'b0;
  logic i_phase_added = 1'b0;
  logic i_start_initial = 1'b0;
  logic i_start_event = 1'b0;
  logic i_scl, host_sda, i_sda, o_sda, o_sda_oe_n, o_refresh_pulse, o_refresh_busy;
  logic o_phase_drop_allowed, o_write_locked;
  logic [9:0] o_hs_duty_limit, o_ls_duty_limit, o_flyback_duty_limit;
  logic [3:0] o_refresh_width_div;
  logic [11:0] o_constant_current_loop_mv, o_average_current_limit_mv;
  logic [31:0] seed = 32'h0000e089;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  // Open-drain line with a pull-up
  assign i_sda = host_sda & (o_sda_oe_n | o_sda);
  always #20 i_clk = ~i_clk;
  pmbus_host_model host (.i_clk, .i_sda, .o_scl(i_scl), .o_sda(host_sda));
  converter_config_regs #(.BLANK_SHORT_US(BS), .BLANK_LONG_US(BL)) DUT (.i_clk, .i_nrst,
    .i_scl, .i_sda, .o_sda, .o_sda_oe_n, .i_boost_mode, .i_phase_added, .i_start_initial,
    .i_start_event, .o_hs_duty_limit, .o_ls_duty_limit, .o_flyback_duty_limit,
    .o_refresh_pulse, .o_refresh_busy, .o_refresh_width_div, .o_phase_drop_allowed,
    .o_constant_current_loop_mv, .o_average_current_limit_mv, .o_write_locked);
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [11:0] thr(input logic [11:0] b, input logic [2:0] c);
    return b - 12'h064 * 12'(c);
  endfunction : thr
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic a;
    host.start();
    host.send({`DEV_ADDR_DEFAULT, 1'b0}, a);
    host.send(cmd, a);
    host.send(d, a);
    chk(12'(a), 12'h001);
    host.stop();
    host.w(4);
  endtask : wr
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    host.start();
    host.send({`DEV_ADDR_DEFAULT, 1'b0}, a);
    host.send(cmd, a);
    host.start();
    host.send({`DEV_ADDR_DEFAULT, 1'b1}, a);
    host.recv(d, 1'b1);
    host.stop();
    host.w(4);
    chk(12'(d), 12'(exp));
  endtask : rd
  // Busy drops in the same cycle as the last pulse, so an early stop shows as a short count
  task automatic burst(input logic ini, input int exp);
    int n, g, t;
    n = 0;
    g = 0;
    t = 0;
    i_start_initial = ini;
    i_start_event = ~ini;
    @(negedge i_clk);
    i_start_initial = 1'b0;
    i_start_event = 1'b0;
    while (t < 45000 && !(t > 2 && o_refresh_busy !== 1'b1)) begin
      @(negedge i_clk);
      t++;
      g++;
      if (o_refresh_pulse === 1'b1) begin
        if (n > 0) chk(12'(g), 12'(100 * `TICK_CYCLES));
        n++;
        g = 0;
      end
    end
    chk(12'(n), 12'(exp));
  endtask : burst
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 120000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    logic [7:0] r, m;
    int n, b;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'b1;
    host.w(6);
    chk(12'(o_flyback_duty_limit), 12'h395);
    chk(12'(o_ls_duty_limit), 12'h3e8);
    chk(12'(o_refresh_width_div), 12'h00c);
    chk(o_constant_current_loop_mv, 12'h960);
    chk(o_average_current_limit_mv, 12'ha8c);
    chk(12'(o_write_locked), 12'h000);
    for (int k = 0; k < 4; k++) rd(REGS[k], 8'h00);
    for (int k = 0; k < 8; k++) begin
      m = rnd();
      r = {m[7:3], 3'(k)};
      wr(`REG_MAX_DUTY, r);
      i_boost_mode = m[0];
      rd(`REG_MAX_DUTY, {5'h00, r[2:0]});
      chk(12'(o_flyback_duty_limit), 12'(DUTY[k]));
      chk(12'(m[0] ? o_ls_duty_limit : o_hs_duty_limit), 12'(DUTY[k]));
      chk(12'(m[0] ? o_hs_duty_limit : o_ls_duty_limit), 12'h3e8);
    end
    for (int k = 0; k < 6; k++) begin
      r = (k == 0) ? 8'hff : rnd();
      wr(`REG_THRESHOLDS, r);
      rd(`REG_THRESHOLDS, r & 8'h3f);
      chk(o_constant_current_loop_mv, thr(12'h960, r[2:0]));
      chk(o_average_current_limit_mv, thr(12'ha8c, r[5:3]));
    end
    for (int k = 0; k < 4; k++) begin
      m = rnd();
      r = {m[7], k[1], m[5:4], k[0], 3'h1};
      wr(`REG_BOOT_REFRESH, r);
      rd(`REG_BOOT_REFRESH, r & 8'h5f);
      chk(12'(o_refresh_width_div), k[0] ? 12'h006 : 12'h00c);
      b = k[1] ? BL : BS;
      i_phase_added = 1'b1;
      @(negedge i_clk);
      i_phase_added = 1'b0;
      n = 0;
      while (o_phase_drop_allowed !== 1'b1 && n < 2000) begin
        @(negedge i_clk);
        n++;
      end
      chk(12'(n >= (b - 1) * `TICK_CYCLES && n <= b * `TICK_CYCLES + 3), 12'h001);
    end
    wr(`REG_BOOT_REFRESH, 8'h11);
    burst(1'b1, 16);
    wr(`REG_BOOT_REFRESH, 8'h01);
    burst(1'b0, 4);
    wr(`REG_THRESHOLDS, 8'h15);
    wr(`REG_WRITE_LOCK, 8'hff);
    chk(12'(o_write_locked), 12'h001);
    rd(`REG_WRITE_LOCK, 8'h80);
    wr(`REG_THRESHOLDS, 8'h2a);
    wr(`REG_MAX_DUTY, 8'h02);
    rd(`REG_THRESHOLDS, 8'h15);
    rd(`REG_MAX_DUTY, 8'h07);
    chk(o_constant_current_loop_mv, thr(12'h960, 3'h5));
    wr(`REG_WRITE_LOCK, 8'h00);
    chk(12'(o_write_locked), 12'h000);
    wr(`REG_THRESHOLDS, 8'h2a);
    rd(`REG_THRESHOLDS, 8'h2a);
    conclude();
  end
endmodule : converter_config_regs_test
bind converter_config_regs converter_config_regs_chk chk (.i_clk, .i_nrst, .i_boost_mode,
  .i_phase_added, .i_start_initial, .i_start_event, .o_sda_oe_n, .o_hs_duty_limit,
  .o_ls_duty_limit, .o_flyback_duty_limit, .o_refresh_pulse, .o_refresh_busy,
  .o_refresh_width_div, .o_phase_drop_allowed, .o_constant_current_loop_mv,
  .o_average_current_limit_mv, .o_write_locked);
